// *** verilog/gsr_gain_regs.sv ***
// gain-swap ramp control, digital gain registers and axi4-lite slave
//
// Overview of operation
// R1: fine sub-range bit gives finer ramp step
// R2: fine sub-range only matters with ramp enabled
// R3: ramp off applies whole swap at once
// R4: ramp steps 1.5 dB, fine 0.5 dB
// R5: five-bit field caps coarse steps, reset 0x14
// R6: cap counts coarse steps even when fine
// R7: input gains 7-bit codes, 0.75 dB linear
// R8: output gains 8-bit codes, 0.75 dB linear
// R9: swaps start once level below trigger
// R10: anti-clip level removes all steps immediately
// R11: analogue update lags digital by delay ticks
// R12: new gain codes take effect at frame start
`timescale 1ns/1ps
`default_nettype none
module gsr_gain_regs
    import gsr_pkg::*;
#(
    parameter int SAMPLE_W = 24,
    parameter int FIFO_DEPTH = 4
) (
    // clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  arst_n,
    // axi4-lite write address and data
    input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    // axi4-lite write response
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    // axi4-lite read
    input  wire logic [ADDR_W-1:0]     s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    // sample stream in, first marks the first sample of a frame
    input  wire logic [SAMPLE_W-1:0]   sampleIn,
    input  wire logic                  sampleFirstIn,
    input  wire logic                  sampleInValid,
    output logic                       sampleInReady,
    // sample stream out
    output logic [SAMPLE_W-1:0]        sampleOut,
    output logic                       sampleFirstOut,
    output logic                       sampleOutValid,
    input  wire logic                  sampleOutReady,
    // level detector and swap request
    input  wire logic [3:0]            signalAtten,
    input  wire logic [4:0]            swapRequest,
    input  wire logic                  fs8Tick,
    // gain-swap results in 0.5 dB sub-steps
    output logic [6:0]                 digitalSwap,
    output logic [6:0]                 analogSwap,
    // gain codes in force for the current frame
    output logic [IN_GAIN_W-1:0]       input1_left_level,
    output logic [IN_GAIN_W-1:0]       input1_right_level,
    output logic [IN_GAIN_W-1:0]       input2_left_level,
    output logic [IN_GAIN_W-1:0]       input2_right_level,
    output logic [OUT_GAIN_W-1:0]      output1_left_level,
    output logic [OUT_GAIN_W-1:0]      output1_right_level
);
    // reset release through two flops
    logic rstMeta;   // first stage, read only by the second
    logic rstN;      // released reset used everywhere
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rstMeta <= 1'b0;
            rstN    <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstN    <= rstMeta;
        end
    end

    // software copies of the registers
    logic [7:0] rampCtrl;    // ramp enable, sub-range, step cap
    logic [7:0] syncDelay;   // analogue lag in fs*8 ticks
    logic [7:0] levels;      // trigger and anti-clip levels
    logic [7:0] gainSw [6];  // written gain codes, in1l..out1r

    // ---------------- write channel ----------------
    logic [ADDR_W-1:0] awAddr;   // captured write address
    logic              awHeld;   // address waiting for data
    logic [31:0]       wData;    // captured write data
    logic [3:0]        wStrb;    // captured strobes
    logic              wHeld;    // data waiting for address
    assign s_axi_awready = !awHeld;
    assign s_axi_wready  = !wHeld;

    // decode of a word index to one of the gain slots
    function automatic logic [2:0] gain_slot(input logic [7:0] idx);
        gain_slot = (idx >= IDX_IN1L && idx <= IDX_OUT1R) ? 3'(idx - IDX_IN1L) : 3'h7;
    endfunction : gain_slot

    // mapped check shared by both channels
    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        logic [7:0] idx;
        idx = a[9:2];
        is_mapped = (a[ADDR_W-1:10] == '0) && (idx == IDX_SYNC_DELAY ||
                    idx == IDX_LEVELS || idx == IDX_RAMP_CTRL ||
                    idx == IDX_STATUS || gain_slot(idx) != 3'h7);
    endfunction : is_mapped

    wire        doWrite  = awHeld && wHeld && !s_axi_bvalid;
    wire [7:0]  wIdx     = awAddr[9:2];
    wire        wMapped  = is_mapped(awAddr);
    wire        wLane0   = wStrb[0];
    wire [2:0]  wSlot    = gain_slot(wIdx);

    // capture address and data in either order
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            awHeld <= 1'b0;
            wHeld  <= 1'b0;
            awAddr <= '0;
            wData  <= '0;
            wStrb  <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awAddr <= s_axi_awaddr;
                awHeld <= 1'b1;
            end else if (doWrite) begin
                awHeld <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wData <= s_axi_wdata;
                wStrb <= s_axi_wstrb;
                wHeld <= 1'b1;
            end else if (doWrite) begin
                wHeld <= 1'b0;
            end
        end
    end

    // response one cycle after both halves are held
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wMapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // register writes; only byte lane 0 carries data
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            rampCtrl  <= RAMP_CTRL_RST;   // R5
            syncDelay <= SYNC_DELAY_RST;
            levels    <= LEVELS_RST;
            for (int i = 0; i < 6; i++) gainSw[i] <= GAIN_RST;
        end else if (doWrite && wLane0 && wMapped) begin
            if (wIdx == IDX_RAMP_CTRL) rampCtrl <= {1'b0, wData[6:0]};
            if (wIdx == IDX_SYNC_DELAY) syncDelay <= wData[7:0];
            if (wIdx == IDX_LEVELS) levels <= {wData[7:4], 1'b0, wData[2:0]};
            // input gains hold seven bits, the top bit reads zero
            if (wSlot < 3'h4) gainSw[wSlot] <= {1'b0, wData[6:0]};   // R7
            // output gains use all eight bits
            if (wSlot == 3'h4 || wSlot == 3'h5) gainSw[wSlot] <= wData[7:0];   // R8
        end
    end

    // ---------------- sample path ----------------
    wire frameTick = sampleOutValid && sampleOutReady && sampleFirstOut;
    gsr_fifo #(
        .WIDTH (SAMPLE_W + 1),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .ref_clk  (ref_clk),
        .rstN     (rstN),
        .inData   ({sampleFirstIn, sampleIn}),
        .inValid  (sampleInValid),
        .inReady  (sampleInReady),
        .outData  ({sampleFirstOut, sampleOut}),
        .outValid (sampleOutValid),
        .outReady (sampleOutReady)
    );

    // gain codes move to the datapath only as a frame starts, so no frame
    // ever sees a half-written gain
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            input1_left_level   <= IN_GAIN_W'(GAIN_RST);
            input1_right_level  <= IN_GAIN_W'(GAIN_RST);
            input2_left_level   <= IN_GAIN_W'(GAIN_RST);
            input2_right_level  <= IN_GAIN_W'(GAIN_RST);
            output1_left_level  <= GAIN_RST;
            output1_right_level <= GAIN_RST;
        end else if (frameTick) begin   // R12
            input1_left_level   <= gainSw[0][IN_GAIN_W-1:0];   // R7
            input1_right_level  <= gainSw[1][IN_GAIN_W-1:0];
            input2_left_level   <= gainSw[2][IN_GAIN_W-1:0];
            input2_right_level  <= gainSw[3][IN_GAIN_W-1:0];
            output1_left_level  <= gainSw[4];   // R8
            output1_right_level <= gainSw[5];
        end
    end

    // ---------------- gain swap ----------------
    wire       rampEn    = rampCtrl[RAMP_BIT];
    wire       subrEn    = rampCtrl[SUBR_BIT];
    wire [4:0] stepCap   = rampCtrl[STEPS_MSB:0];
    // cap applies to coarse steps, then scaled to sub-steps
    wire [4:0] capped    = (swapRequest > stepCap) ? stepCap : swapRequest;   // R5
    wire [6:0] targetSub = gsr_to_sub(capped);   // R6
    // sub-range only narrows the step while ramping is on
    wire [6:0] stepSize  = (rampEn && subrEn) ? FINE_SUB : COARSE_SUB;   // R1 R2 R4
    wire       belowTrig = signalAtten >= levels[SIG_LVL_MSB:SIG_LVL_LSB];   // R9
    wire       clipNow   = signalAtten < {1'b0, levels[CLIP_LVL_MSB:0]};   // R10
    gsr_swap_t swapState;   // waiting for trigger or running

    // next digital position: jump, ramp up, ramp down
    logic [6:0] next_digital;
    always_comb begin
        next_digital = digitalSwap;
        if (!rampEn) begin
            next_digital = targetSub;   // R3
        end else if (digitalSwap < targetSub) begin
            next_digital = (targetSub - digitalSwap > stepSize) ?
                           7'(digitalSwap + stepSize) : targetSub;   // R4
        end else if (digitalSwap > targetSub) begin
            next_digital = (digitalSwap - targetSub > stepSize) ?
                           7'(digitalSwap - stepSize) : targetSub;   // R4
        end
    end

    // swap state; anti-clip acts at once, not waiting for a frame
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            swapState   <= SWAP_WAIT;
            digitalSwap <= '0;
        end else begin
            case (swapState)
                SWAP_WAIT: begin
                    if (!clipNow && belowTrig) swapState <= SWAP_RUN;   // R9
                end
                SWAP_RUN: begin
                    if (clipNow) begin
                        swapState   <= SWAP_WAIT;   // R10
                        digitalSwap <= '0;
                    end else if (frameTick) begin
                        digitalSwap <= next_digital;
                    end
                end
                default: swapState <= SWAP_WAIT;
            endcase
        end
    end

    // analogue follower: restarts its delay each time digital moves
    logic [7:0] delayCnt;    // remaining fs*8 ticks
    logic       delayRun;    // a pending analogue update
    logic [6:0] pendSwap;    // value waiting to go analogue
    logic [6:0] prevDigital; // digital value last cycle
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            prevDigital <= '0;
            delayCnt    <= '0;
            delayRun    <= 1'b0;
            pendSwap    <= '0;
            analogSwap  <= '0;
        end else begin
            prevDigital <= digitalSwap;
            if (digitalSwap != prevDigital) begin
                delayCnt <= syncDelay;   // R11
                pendSwap <= digitalSwap;
                delayRun <= 1'b1;
            end else if (delayRun && delayCnt == 8'h00) begin
                analogSwap <= pendSwap;   // R11
                delayRun   <= 1'b0;
            end else if (delayRun && fs8Tick) begin
                delayCnt <= 8'(delayCnt - 1'b1);
            end
        end
    end

    // ---------------- read channel ----------------
    wire [7:0]  rIdx    = s_axi_araddr[9:2];
    wire [2:0]  rSlot   = gain_slot(rIdx);
    wire [31:0] statusW = {15'h0, delayRun, analogSwap, digitalSwap,
                           1'b0, swapState == SWAP_RUN};
    logic [31:0] readMux;
    always_comb begin
        readMux = 32'h0;
        if (rIdx == IDX_RAMP_CTRL) readMux = {24'h0, rampCtrl};
        if (rIdx == IDX_SYNC_DELAY) readMux = {24'h0, syncDelay};
        if (rIdx == IDX_LEVELS) readMux = {24'h0, levels};
        if (rIdx == IDX_STATUS) readMux = statusW;
        if (rSlot != 3'h7) readMux = {24'h0, gainSw[rSlot]};
    end
    assign s_axi_arready = !s_axi_rvalid;

    // read answer one cycle after the address is taken
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= is_mapped(s_axi_araddr) ? readMux : 32'h0;
            s_axi_rresp  <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ---------------- checks ----------------
    wire [6:0] moveSize = (digitalSwap > prevDigital) ? 7'(digitalSwap - prevDigital)
                                                      : 7'(prevDigital - digitalSwap);
    a_fine_step_size: assert property (@(posedge ref_clk) disable iff (!rstN) // R1
        $past(frameTick && swapState == SWAP_RUN && rampEn && subrEn && !clipNow)
        |-> moveSize <= 7'h01) else $error("fine ramp moved more than one sub-step");
    a_jump_no_ramp: assert property (@(posedge ref_clk) disable iff (!rstN) // R3
        frameTick && swapState == SWAP_RUN && !rampEn && !clipNow
        |=> digitalSwap == $past(targetSub)) else $error("ramp off did not jump");
    a_subr_ignored: assert property (@(posedge ref_clk) disable iff (!rstN) // R2
        !rampEn |-> stepSize == COARSE_SUB) else $error("sub-range acted without ramp");
    a_coarse_step_size: assert property (@(posedge ref_clk) disable iff (!rstN) // R4
        $past(frameTick && swapState == SWAP_RUN && rampEn && !subrEn && !clipNow)
        |-> moveSize <= COARSE_SUB) else $error("coarse ramp step too large");
    a_cap_coarse: assert property (@(posedge ref_clk) disable iff (!rstN) // R6
        swapRequest > stepCap |-> targetSub == 7'({2'h0, stepCap} * 7'h03))
        else $error("step cap not counted in coarse steps");
    a_trigger_gate: assert property (@(posedge ref_clk) disable iff (!rstN) // R9
        swapState == SWAP_WAIT |-> digitalSwap == 7'h00) else $error("swap applied before trigger");
    a_anticlip_clear: assert property (@(posedge ref_clk) disable iff (!rstN) // R10
        swapState == SWAP_RUN && clipNow |=> digitalSwap == 7'h00 && swapState == SWAP_WAIT)
        else $error("anti-clip did not clear swaps");
    a_analog_lag: assert property (@(posedge ref_clk) disable iff (!rstN) // R11
        analogSwap != $past(analogSwap) |-> $past(delayRun && delayCnt == 8'h00))
        else $error("analogue update outside delay expiry");
    a_frame_update: assert property (@(posedge ref_clk) disable iff (!rstN) // R12
        output1_left_level != $past(output1_left_level) |-> $past(frameTick))
        else $error("gain changed off a frame boundary");
endmodule : gsr_gain_regs
`default_nettype wire

// *** verilog/gsr_pkg.sv ***
// package of register indices, field positions, reset values and types for the gain block
package gsr_pkg;
    // register indices; the byte address on the bus is four times the index
    localparam logic [7:0] IDX_SYNC_DELAY = 8'h57;
    localparam logic [7:0] IDX_LEVELS     = 8'h5a;
    localparam logic [7:0] IDX_RAMP_CTRL  = 8'h5b;
    localparam logic [7:0] IDX_STATUS     = 8'h60;
    localparam logic [7:0] IDX_IN1L       = 8'hf4;
    localparam logic [7:0] IDX_IN1R       = 8'hf5;
    localparam logic [7:0] IDX_IN2L       = 8'hf6;
    localparam logic [7:0] IDX_IN2R       = 8'hf7;
    localparam logic [7:0] IDX_OUT1L      = 8'hf8;
    localparam logic [7:0] IDX_OUT1R      = 8'hf9;
    localparam int         ADDR_W         = 12;
    // field positions in the ramp control register
    localparam int SUBR_BIT  = 6;
    localparam int RAMP_BIT  = 5;
    localparam int STEPS_MSB = 4;
    // field positions in the levels register
    localparam int SIG_LVL_MSB  = 7;
    localparam int SIG_LVL_LSB  = 4;
    localparam int CLIP_LVL_MSB = 2;
    // gain code widths
    localparam int IN_GAIN_W  = 7;
    localparam int OUT_GAIN_W = 8;
    // reset values
    localparam logic [7:0] RAMP_CTRL_RST  = 8'h74;
    localparam logic [7:0] GAIN_RST       = 8'h6f;
    localparam logic [7:0] SYNC_DELAY_RST = 8'ha3;
    localparam logic [7:0] LEVELS_RST     = 8'h01;
    // ramp step sizes in 0.5 dB units
    localparam logic [6:0] COARSE_SUB = 7'h03;
    localparam logic [6:0] FINE_SUB   = 7'h01;
    // bus answers
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // gain-swap states
    typedef enum logic {SWAP_WAIT, SWAP_RUN} gsr_swap_t;
    // coarse 1.5 dB steps expressed in 0.5 dB sub-steps
    function automatic logic [6:0] gsr_to_sub(input logic [4:0] steps);
        gsr_to_sub = 7'({2'h0, steps} * 7'h03);
    endfunction : gsr_to_sub
endpackage : gsr_pkg

// *** verilog/gsr_fifo.sv ***
// small flip-flop fifo with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module gsr_fifo #(
    parameter int WIDTH = 25,
    parameter int DEPTH = 4
) (
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rstN,
    // filling side
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    // draining side
    output logic      [WIDTH-1:0] outData,
    output logic                  outValid,
    input  wire logic             outReady
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];   // storage words
    logic [PW-1:0]    wrPtr;         // next slot to fill
    logic [PW-1:0]    rdPtr;         // oldest slot
    logic [PW:0]      count;         // words held
    wire              doPush = inValid && inReady;
    wire              doPop  = outValid && outReady;

    // full and empty straight from the count
    assign inReady  = (count != (PW+1)'(DEPTH));
    assign outValid = (count != '0);
    assign outData  = mem[rdPtr];

    // pointer wrap handles depths that are not powers of two
    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        bump = (p == PW'(DEPTH-1)) ? '0 : PW'(p + 1'b1);
    endfunction : bump

    // pointers and count
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            if (doPush) wrPtr <= bump(wrPtr);
            if (doPop) rdPtr <= bump(rdPtr);
            count <= (PW+1)'(count + {PW'(0), doPush} - {PW'(0), doPop});
        end
    end

    // storage carries no reset; only valid words are ever read
    always_ff @(posedge ref_clk) begin
        if (doPush) mem[wrPtr] <= inData;
    end
endmodule : gsr_fifo
`default_nettype wire

// *** bench/gsr_gain_regs_tb.sv ***
// self-checking bench for the gain-swap ramp and digital gain block
`timescale 1ns/1ps
`default_nettype none
module gsr_gain_regs_tb;
    import gsr_pkg::*;
    // bus master side
    logic ref_clk, arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0]       s_axi_wdata;
    logic [3:0]        s_axi_wstrb;
    wire logic         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire logic [1:0]   s_axi_bresp, s_axi_rresp;
    wire logic [31:0]  s_axi_rdata;
    // stream and detector side
    logic [23:0]       sampleIn;
    logic              sampleFirstIn, sampleInValid, sampleOutReady, fs8Tick;
    wire logic [23:0]  sampleOut;
    wire logic         sampleInReady, sampleFirstOut, sampleOutValid;
    logic [3:0]        signalAtten;
    logic [4:0]        swapRequest;
    wire logic [6:0]   digitalSwap, analogSwap;
    wire logic [6:0]   input1_left_level, input1_right_level, input2_left_level, input2_right_level;
    wire logic [7:0]   output1_left_level, output1_right_level;
    wire logic [7:0]   lv [6];  // level outputs in register order
    int                err_count = 0;
    int                checks = 0;
    logic [31:0]       seed = 32'h57;  // xorshift state, fixed start
    assign lv[0] = {1'b0, input1_left_level};
    assign lv[1] = {1'b0, input1_right_level};
    assign lv[2] = {1'b0, input2_left_level};
    assign lv[3] = {1'b0, input2_right_level};
    assign lv[4] = output1_left_level;
    assign lv[5] = output1_right_level;
    gsr_gain_regs dut (.*);
    // pseudo-random source, repeatable run to run
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    // expected swap after k frames: steps of st half-dB toward the capped target
    function automatic logic [31:0] ramp(input int k, input int st, input int tgt);
        return (k * st > tgt) ? 32'(tgt) : 32'(k * st);
    endfunction : ramp
    task automatic end_sim();
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // one write; each channel released on the edge that takes it
    task automatic axi_wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
        logic ah, wh, bh;
        logic [1:0] r;
        @(posedge ref_clk);
        s_axi_awaddr <= {2'h0, idx, 2'h0};
        s_axi_wdata <= {24'h0, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            #1 {ah, wh, bh, r} = {s_axi_awvalid & s_axi_awready, s_axi_wvalid & s_axi_wready,
                                 s_axi_bvalid, s_axi_bresp};
            @(posedge ref_clk);
            if (ah) s_axi_awvalid <= 1'b0;
            if (wh) s_axi_wvalid <= 1'b0;
        end while (!bh);
        s_axi_bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, r});
    endtask : axi_wr
    // one read, compared with the expected word and answer code
    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] e, input logic [1:0] er);
        logic ah, rh;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge ref_clk);
        s_axi_araddr <= {2'h0, idx, 2'h0};
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            #1 {ah, rh, d, r} = {s_axi_arvalid & s_axi_arready, s_axi_rvalid,
                                 s_axi_rdata, s_axi_rresp};
            @(posedge ref_clk);
            if (ah) s_axi_arvalid <= 1'b0;
        end while (!rh);
        s_axi_rready <= 1'b0;
        chk("rdata", e, d);
        chk("rresp", {30'h0, er}, {30'h0, r});
    endtask : rd_chk
    // push one sample and wait for it to pop; the fifo must be empty on entry
    task automatic frame(input logic first);
        logic [23:0] v;
        logic h;
        @(posedge ref_clk);
        v = 24'(xs());
        sampleIn <= v;
        sampleFirstIn <= first;
        sampleInValid <= 1'b1;
        do begin
            #1 h = sampleInReady;
            @(posedge ref_clk);
        end while (!h);
        sampleInValid <= 1'b0;
        do begin
            #1 h = sampleOutValid & sampleOutReady;
            if (h) chk("sampleOut", {8'h0, v}, {8'h0, sampleOut});
            if (h) chk("first", {31'h0, first}, {31'h0, sampleFirstOut});
            @(posedge ref_clk);
        end while (!h);
    endtask : frame
    task automatic tick();
        @(posedge ref_clk);
        fs8Tick <= 1'b1;
        @(posedge ref_clk);
        fs8Tick <= 1'b0;
        repeat (2) @(posedge ref_clk);
    endtask : tick
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    // hang guard, far beyond the few hundred cycles the run needs
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_count++;
        end_sim();
    end
    initial begin
        logic [7:0] code [6];
        logic [23:0] q [$];
        logic [7:0] ct [4];
        int st [4];
        int i, k, c, cnt;
        ct = '{8'h03, 8'h43, 8'h23, 8'h63};
        st = '{9, 9, 3, 1};
        {arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, sampleIn, sampleFirstIn, sampleInValid} = '0;
        {fs8Tick, signalAtten} = '0;
        s_axi_wstrb = 4'hf;
        sampleOutReady = 1'b1;
        swapRequest = 5'h05;
        repeat (8) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        // reset values: ramp on, fine on, cap of twenty coarse steps
        rd_chk(IDX_RAMP_CTRL, 32'h74, 2'h0);
        for (i = 0; i < 6; i++) rd_chk(IDX_IN1L + 8'(i), 32'h6f, 2'h0);
        // unmapped places answer with an error
        rd_chk(8'h00, 32'h0, 2'h2);
        axi_wr(8'h01, 8'h5a, 2'h2);
        // gain codes: all ones first, then random; held until a frame start pops
        for (k = 0; k < 2; k++) begin
            for (i = 0; i < 6; i++) begin
                code[i] = (k == 0) ? 8'hff : 8'(xs());
                if (i < 4) code[i][7] = 1'b0;
                axi_wr(IDX_IN1L + 8'(i), (k == 0) ? 8'hff : code[i], 2'h0);
                rd_chk(IDX_IN1L + 8'(i), {24'h0, code[i]}, 2'h0);
            end
            frame(1'b0);
            #1 chk("level held", (k == 0) ? 32'h6f : 32'h7f, {24'h0, lv[0]});
            frame(1'b1);
            #1 for (i = 0; i < 6; i++) chk("level", {24'h0, code[i]}, {24'h0, lv[i]});
        end
        // fifo: far side stalls until full, then drains in order
        @(posedge ref_clk);
        sampleOutReady <= 1'b0;
        sampleInValid <= 1'b1;
        cnt = 0;
        for (i = 0; i < 7; i++) begin
            #1 k = int'(sampleInReady);
            @(posedge ref_clk);
            if (k == 1) begin
                q.push_back(sampleIn);
                cnt++;
                sampleIn <= 24'(xs());
            end
        end
        sampleInValid <= 1'b0;
        sampleOutReady <= 1'b1;
        chk("fill", 4, cnt);
        while (q.size() > 0) begin
            #1 chk("drain", {8'h1, q.pop_front()}, {7'h0, sampleOutValid, sampleOut});
            @(posedge ref_clk);
        end
        #1 chk("empty", 0, {31'h0, sampleOutValid});
        // swap stepping per control setting; target is min(5, 3) coarse steps
        axi_wr(IDX_SYNC_DELAY, 8'h03, 2'h0);
        for (c = 0; c < 4; c++) begin
            axi_wr(IDX_RAMP_CTRL, ct[c], 2'h0);
            signalAtten <= 4'h0;
            repeat (3) @(posedge ref_clk);
            #1 chk("anticlip", 0, {25'h0, digitalSwap});
            @(posedge ref_clk);
            signalAtten <= 4'h4;
            for (k = 1; k < 11; k++) begin
                frame(1'b1);
                #1 chk("digitalSwap", ramp(k, st[c], 9), {25'h0, digitalSwap});
            end
        end
        // trigger level: no swap while the input sits above it
        signalAtten <= 4'h0;
        axi_wr(IDX_LEVELS, 8'h81, 2'h0);
        axi_wr(IDX_RAMP_CTRL, 8'h03, 2'h0);
        signalAtten <= 4'h4;
        repeat (2) frame(1'b1);
        signalAtten <= 4'h8;
        #1 chk("trigger wait", 0, {25'h0, digitalSwap});
        frame(1'b1);
        frame(1'b1);
        #1 chk("trigger run", 9, {25'h0, digitalSwap});
        // analogue copy follows only after three ticks
        repeat (2) tick();
        #1 chk("analog early", 0, {25'h0, analogSwap});
        tick();
        repeat (3) @(posedge ref_clk);
        #1 chk("analog late", 9, {25'h0, analogSwap});
        rd_chk(IDX_STATUS, {16'h0, 7'h09, 7'h09, 2'h1}, 2'h0);
        end_sim();
    end
endmodule : gsr_gain_regs_tb
`default_nettype wire
